// ### core/pport_consts.svh
`ifndef PPORT_CONSTS_SVH
`define PPORT_CONSTS_SVH

// ----------------------------------------------------------------
// Control register layout
// ----------------------------------------------------------------
`define CTRL_LATCH_BIT 0
`define CTRL_LINEFEED_BIT 1
`define CTRL_INIT_BIT 2
`define CTRL_SELECT_BIT 3
`define CTRL_DIR_BIT 5
`define CTRL_RESET 8'h04

// ----------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------
`define STAT_BUSY_BIT 7
`define STAT_ACCEPT_BIT 6
`define STAT_PAPER_BIT 5
`define STAT_ONLINE_BIT 4
`define STAT_FAULT_BIT 3
`define STAT_RESET 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define IRQ_PULSE_NS 100
`define IRQ_PULSE_CYC \
  ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Data path
// ----------------------------------------------------------------
`define DATA_WIDTH 8
`define FIFO_DEPTH 8
`define DATA_RESET 8'h00

`endif

// ### core/pport_pkg.sv
package pport_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Peripheral status pins, true pin levels
  typedef struct packed {
    logic busy;
    logic acceptN;
    logic paperOut;
    logic online;
    logic faultN;
  } periph_status_t;

  // Open-drain style pin drive
  typedef struct packed {
    logic level;
    logic enable;
  } pin_drive_t;

  // Outbound transfer sequencer
  typedef enum logic [0:0] {
    XFER_IDLE,
    XFER_WAIT_ACCEPT
  } xfer_state_t;

endpackage

// ### core/printer_port_pin_interface.sv
`timescale 1ns/10ps
`include "pport_consts.svh"

// ----------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------
module pport_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wrPtr_reg, wrPtr_next;
  logic [AW-1:0] rdPtr_reg, rdPtr_next;
  logic [AW:0] count_reg, count_next;
  logic notFull_reg, notFull_next;
  logic notEmpty_reg, notEmpty_next;
  logic doPush, doPop;

  // Pointer wrap
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      bump = '0;
    end else begin
      bump = p + 1'b1;
    end
  endfunction

  assign inReady = notFull_reg;
  assign outValid = notEmpty_reg;
  assign outData = mem_reg[rdPtr_reg];
  assign doPush = inValid && notFull_reg;
  assign doPop = outReady && notEmpty_reg;

  // Next pointers, count and flags
  always_comb begin
    mem_next = mem_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (doPush) begin
      mem_next[wrPtr_reg] = inData;
      wrPtr_next = bump(wrPtr_reg);
    end
    if (doPop) begin
      rdPtr_next = bump(rdPtr_reg);
    end
    if (doPush && !doPop) begin
      count_next = count_reg + 1'b1;
    end else if (doPop && !doPush) begin
      count_next = count_reg - 1'b1;
    end
    notFull_next = (count_next != (AW+1)'(DEPTH));
    notEmpty_next = (count_next != '0);
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      notFull_reg <= 1'b0;
      notEmpty_reg <= 1'b0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      notFull_reg <= notFull_next;
      notEmpty_reg <= notEmpty_next;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_sys) begin
    mem_reg <= mem_next;
  end
endmodule

// ----------------------------------------------------------------
// Printer port pin logic
// ----------------------------------------------------------------
module printer_port_pin_interface
  import pport_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control register
  input wire logic ctrlWrEn,
  input wire logic [7:0] ctrlWrData,
  // Status and data readback
  input wire logic statusRdEn,
  output logic [7:0] statusRdData,
  output logic [7:0] portRdData,
  // Mode selection
  input wire logic eppEnable,
  input wire logic ecpEnable,
  // Host byte stream
  input wire logic hostDataValid,
  input wire logic [7:0] hostData,
  output logic hostDataReady,
  // Host EPP bus cycle
  input wire logic hostCycleActive,
  output logic hostReadyOut,
  output logic hostReadyOe,
  // Shared interrupt line
  output logic sharedIrqOut,
  output logic sharedIrqOe,
  // Peripheral control outputs
  output logic dataLatchPulseOutN,
  output logic peripheralSelectOutN,
  output logic peripheralInitOutN,
  output logic lineFeedOutN,
  // Peripheral status inputs
  input wire logic busyIn,
  input wire logic peripheralAcceptInN,
  input wire logic paperOutIn,
  input wire logic peripheralOnlineIn,
  input wire logic peripheralFaultInN,
  // Port data lines
  input wire logic [7:0] portDataLinesIn,
  output logic [7:0] portDataLinesOut,
  output logic portDataLinesOe
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  periph_status_t statMeta_reg, statSync_reg;
  logic [7:0] dataMeta_reg, dataSync_reg;
  periph_status_t statPins;
  logic acceptPrev_reg;

  assign statPins = '{busy: busyIn, acceptN: peripheralAcceptInN,
                      paperOut: paperOutIn, online: peripheralOnlineIn,
                      faultN: peripheralFaultInN};

  // Two flops on every pin input
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      statMeta_reg <= '0;
      statSync_reg <= '0;
      dataMeta_reg <= `DATA_RESET;
      dataSync_reg <= `DATA_RESET;
      acceptPrev_reg <= 1'b1;
    end else begin
      statMeta_reg <= statPins;
      statSync_reg <= statMeta_reg;
      dataMeta_reg <= portDataLinesIn;
      dataSync_reg <= dataMeta_reg;
      acceptPrev_reg <= statSync_reg.acceptN;
    end
  end

  // Falling edge of the synchronised acknowledge
  logic acceptFall;
  assign acceptFall = acceptPrev_reg && !statSync_reg.acceptN;

  // ----------------------------------------------------------------
  // Control register and pin drive
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg, ctrl_next;
  logic latchN_reg, latchN_next;
  logic selectN_reg, selectN_next;
  logic initN_reg, initN_next;
  logic feedN_reg, feedN_next;
  logic dirOut;

  assign dirOut = !ctrl_reg[`CTRL_DIR_BIT];

  // Control outputs follow the register
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrlWrEn) begin
      ctrl_next = ctrlWrData;
    end
    latchN_next = !ctrl_next[`CTRL_LATCH_BIT];
    selectN_next = !ctrl_next[`CTRL_SELECT_BIT];
    initN_next = ctrl_next[`CTRL_INIT_BIT];
    feedN_next = !ctrl_next[`CTRL_LINEFEED_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg <= `CTRL_RESET;
      latchN_reg <= 1'b1;
      selectN_reg <= 1'b1;
      initN_reg <= 1'b1;
      feedN_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      latchN_reg <= latchN_next;
      selectN_reg <= selectN_next;
      initN_reg <= initN_next;
      feedN_reg <= feedN_next;
    end
  end

  assign dataLatchPulseOutN = latchN_reg;
  assign peripheralSelectOutN = selectN_reg;
  assign peripheralInitOutN = initN_reg;
  assign lineFeedOutN = feedN_reg;

  // ----------------------------------------------------------------
  // Status and data readback
  // ----------------------------------------------------------------
  logic [7:0] status_reg, status_next;
  logic [7:0] portRd_reg, portRd_next;

  // Capture synchronised levels at the read
  always_comb begin
    status_next = status_reg;
    portRd_next = portRd_reg;
    if (statusRdEn) begin
      status_next = `STAT_RESET;
      status_next[`STAT_BUSY_BIT] = !statSync_reg.busy;
      status_next[`STAT_ACCEPT_BIT] = statSync_reg.acceptN;
      status_next[`STAT_PAPER_BIT] = statSync_reg.paperOut;
      status_next[`STAT_ONLINE_BIT] = statSync_reg.online;
      status_next[`STAT_FAULT_BIT] = statSync_reg.faultN;
      portRd_next = dataSync_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_reg <= `STAT_RESET;
      portRd_reg <= `DATA_RESET;
    end else begin
      status_reg <= status_next;
      portRd_reg <= portRd_next;
    end
  end

  assign statusRdData = status_reg;
  assign portRdData = portRd_reg;

  // ----------------------------------------------------------------
  // Outbound byte path
  // ----------------------------------------------------------------
  logic fifoOutValid, fifoOutReady, fifoInReady;
  logic [7:0] fifoOutData;

  pport_fifo #(
    .WIDTH(`DATA_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) txFifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .inValid(hostDataValid),
    .inReady(fifoInReady),
    .inData(hostData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  assign hostDataReady = fifoInReady;

  xfer_state_t xfer_reg, xfer_next;
  logic [7:0] dataOut_reg, dataOut_next;
  logic dataOe_reg, dataOe_next;

  // One byte at a time, held until the peripheral accepts it or the port turns to input
  always_comb begin
    xfer_next = xfer_reg;
    dataOut_next = dataOut_reg;
    fifoOutReady = 1'b0;
    dataOe_next = dirOut;
    case (xfer_reg)
      XFER_IDLE: begin
        if (dirOut && fifoOutValid && !statSync_reg.busy) begin
          fifoOutReady = 1'b1;
          dataOut_next = fifoOutData;
          xfer_next = XFER_WAIT_ACCEPT;
        end
      end
      XFER_WAIT_ACCEPT: begin
        if (acceptFall || !dirOut) begin
          xfer_next = XFER_IDLE;
        end
      end
      default: begin
        xfer_next = XFER_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xfer_reg <= XFER_IDLE;
      dataOut_reg <= `DATA_RESET;
      dataOe_reg <= 1'b0;
    end else begin
      xfer_reg <= xfer_next;
      dataOut_reg <= dataOut_next;
      dataOe_reg <= dataOe_next;
    end
  end

  assign portDataLinesOut = dataOut_reg;
  assign portDataLinesOe = dataOe_reg;

  // ----------------------------------------------------------------
  // Host cycle stretch and shared interrupt
  // ----------------------------------------------------------------
  pin_drive_t ready_reg, ready_next;
  pin_drive_t irq_reg, irq_next;
  logic [3:0] irqCnt_reg, irqCnt_next;
  logic sharedMode;

  assign sharedMode = eppEnable || ecpEnable;

  // Stretch while the peripheral is not busy
  always_comb begin
    ready_next.level = 1'b0;
    ready_next.enable = eppEnable && hostCycleActive
                        && !statSync_reg.busy;
  end

  // In EPP or ECP mode, low pulse on each acknowledge, then release the line; otherwise the line is driven low
  always_comb begin
    irqCnt_next = irqCnt_reg;
    irq_next.level = 1'b0;
    irq_next.enable = 1'b0;
    if (!sharedMode) begin
      irqCnt_next = '0;
      irq_next.enable = 1'b1;
    end else if (acceptFall) begin
      irqCnt_next = 4'(`IRQ_PULSE_CYC);
      irq_next.enable = 1'b1;
    end else if (irqCnt_reg > 4'h1) begin
      irqCnt_next = irqCnt_reg - 4'h1;
      irq_next.enable = 1'b1;
    end else begin
      irqCnt_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ready_reg <= '0;
      irq_reg <= '0;
      irqCnt_reg <= '0;
    end else begin
      ready_reg <= ready_next;
      irq_reg <= irq_next;
      irqCnt_reg <= irqCnt_next;
    end
  end

  assign hostReadyOut = ready_reg.level;
  assign hostReadyOe = ready_reg.enable;
  assign sharedIrqOut = irq_reg.level;
  assign sharedIrqOe = irq_reg.enable;

endmodule

// ### bench/pport_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module pport_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Host side
  input wire logic ctrlWrEn,
  input wire logic [7:0] ctrlWrData,
  input wire logic statusRdEn,
  input wire logic [7:0] statusRdData,
  input wire logic eppEnable,
  input wire logic hostCycleActive,
  input wire logic hostReadyOut,
  input wire logic hostReadyOe,
  input wire logic sharedIrqOut,
  input wire logic sharedIrqOe,
  // Peripheral side
  input wire logic dataLatchPulseOutN,
  input wire logic peripheralSelectOutN,
  input wire logic peripheralInitOutN,
  input wire logic lineFeedOutN,
  input wire logic busyIn,
  input wire logic portDataLinesOe
);
  logic busyPrev_reg;
  logic [2:0] quiet_reg;
  logic [2:0] quiet_next;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Cycles the busy pin has held still
  always_comb begin
    quiet_next = quiet_reg;
    if (busyIn != busyPrev_reg) quiet_next = 3'h0;
    else if (quiet_reg != 3'h7) quiet_next = quiet_reg + 3'h1;
  end

  // Busy history registers
  always_ff @(posedge clk_sys) begin
    busyPrev_reg <= busyIn;
    quiet_reg <= srst ? 3'h0 : quiet_next;
  end

  latch_follow_a: assert property (
    ctrlWrEn |=> dataLatchPulseOutN == !$past(ctrlWrData[0]))
    else $error("latch output wrong");
  select_follow_a: assert property (
    ctrlWrEn |=> peripheralSelectOutN == !$past(ctrlWrData[3]))
    else $error("select output wrong");
  init_follow_a: assert property (
    ctrlWrEn |=> peripheralInitOutN == $past(ctrlWrData[2]))
    else $error("init output wrong");
  feed_follow_a: assert property (
    ctrlWrEn |=> lineFeedOutN == !$past(ctrlWrData[1]))
    else $error("line feed output wrong");
  busy_status_a: assert property (
    statusRdEn && quiet_reg >= 3'h4
    |=> statusRdData[7] == !$past(busyIn, 3))
    else $error("busy status wrong");
  stretch_cause_a: assert property (
    hostReadyOe |-> $past(eppEnable) && $past(hostCycleActive) && !hostReadyOut)
    else $error("ready stretched without cause");
  irq_pulse_a: assert property (
    $rose(sharedIrqOe) && eppEnable && $past(eppEnable)
    |-> sharedIrqOe [*5] ##1 !sharedIrqOe && !sharedIrqOut)
    else $error("interrupt pulse width wrong");
  dir_release_a: assert property (
    ctrlWrEn && ctrlWrData[5] ##1 !ctrlWrEn |=> !portDataLinesOe)
    else $error("data lines driven while input");

  // Main scenarios reached
  cover property (ctrlWrEn && ctrlWrData[5]);
  cover property ($rose(sharedIrqOe) && eppEnable);
  cover property (hostReadyOe);
endmodule

bind printer_port_pin_interface pport_monitor chk (.clk_sys, .srst,
  .ctrlWrEn, .ctrlWrData, .statusRdEn, .statusRdData, .eppEnable,
  .hostCycleActive, .hostReadyOut, .hostReadyOe, .sharedIrqOut,
  .sharedIrqOe, .dataLatchPulseOutN, .peripheralSelectOutN,
  .peripheralInitOutN, .lineFeedOutN, .busyIn, .portDataLinesOe);

// ### bench/pport_printer_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Printer model
// ----------------------------------------------------------------
module pport_printer_model (
  // Clock
  input wire logic clk_sys,
  // From the port
  input wire logic dataLatchPulseOutN,
  input wire logic [7:0] portDataLinesOut,
  input wire logic portDataLinesOe,
  // Bench control
  input wire logic slow,
  input wire logic replyEn,
  input wire logic [7:0] replyByte,
  // To the port, plus the last byte taken for the bench
  output logic busyIn,
  output logic peripheralAcceptInN,
  output logic [7:0] portDataLinesIn,
  output logic [7:0] lastByte
);
  logic [7:0] junk = 8'h5A;

  // Undriven lines show a changing pattern
  always @(posedge clk_sys) junk <= ~junk;
  assign portDataLinesIn = portDataLinesOe ? portDataLinesOut :
    replyEn ? replyByte : junk;

  // Takes a byte per latch pulse, then busy and acknowledge
  initial begin
    busyIn = 1'b0;
    peripheralAcceptInN = 1'b1;
    lastByte = 8'h00;
    forever begin
      @(negedge dataLatchPulseOutN);
      @(posedge clk_sys);
      #1 lastByte = portDataLinesOut;
      busyIn = 1'b1;
      repeat (slow ? 20 : 2) @(posedge clk_sys);
      #1 peripheralAcceptInN = 1'b0;
      busyIn = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 peripheralAcceptInN = 1'b1;
    end
  end
endmodule

// ### bench/printer_port_pin_interface_test.sv
`timescale 1ns/10ps
module printer_port_pin_interface_test;
  logic clk_sys, srst, ctrlWrEn, statusRdEn, eppEnable, ecpEnable;
  logic hostDataValid, hostDataReady, hostCycleActive, hostReadyOut;
  logic hostReadyOe, sharedIrqOut, sharedIrqOe, dataLatchPulseOutN;
  logic peripheralSelectOutN, peripheralInitOutN, lineFeedOutN, busyIn;
  logic peripheralAcceptInN, paperOutIn, peripheralOnlineIn;
  logic peripheralFaultInN, portDataLinesOe, slow, replyEn;
  logic [7:0] ctrlWrData, statusRdData, portRdData, hostData;
  logic [7:0] portDataLinesIn, portDataLinesOut, replyByte, lastByte;
  int errors = 0;
  int samplesChecked = 0;

  printer_port_pin_interface uut (.clk_sys, .srst, .ctrlWrEn,
    .ctrlWrData, .statusRdEn, .statusRdData, .portRdData, .eppEnable,
    .ecpEnable, .hostDataValid, .hostData, .hostDataReady,
    .hostCycleActive, .hostReadyOut, .hostReadyOe, .sharedIrqOut,
    .sharedIrqOe, .dataLatchPulseOutN, .peripheralSelectOutN,
    .peripheralInitOutN, .lineFeedOutN, .busyIn, .peripheralAcceptInN,
    .paperOutIn, .peripheralOnlineIn, .peripheralFaultInN,
    .portDataLinesIn, .portDataLinesOut, .portDataLinesOe);
  pport_printer_model printer (.clk_sys, .dataLatchPulseOutN,
    .portDataLinesOut, .portDataLinesOe, .slow, .replyEn, .replyByte,
    .busyIn, .peripheralAcceptInN, .portDataLinesIn, .lastByte);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d of %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] want, string msg);
    samplesChecked++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED %0t %s: %h not %h", $time, msg, seen, want);
    end
  endtask
  task automatic wr_ctrl(logic [7:0] d);
    ctrlWrEn = 1'b1;
    ctrlWrData = d;
    tick();
    ctrlWrEn = 1'b0;
  endtask
  task automatic rd_status();
    statusRdEn = 1'b1;
    tick();
    statusRdEn = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_ctrl();
    for (int i = 0; i < 16; i++) begin
      wr_ctrl(8'(i));
      check(dataLatchPulseOutN, !i[0], "latch");
      check(lineFeedOutN, !i[1], "line feed");
      check(peripheralInitOutN, i[2], "init");
      check(peripheralSelectOutN, !i[3], "select");
    end
    wr_ctrl(8'h04);
    repeat (30) tick();
  endtask
  task automatic test_status();
    for (int i = 0; i < 8; i++) begin
      {paperOutIn, peripheralOnlineIn, peripheralFaultInN} = 3'(i);
      repeat (3) tick();
      rd_status();
      check(statusRdData, {2'h3, 3'(i), 3'h0}, "status");
    end
  endtask
  task automatic test_dir_in();
    wr_ctrl(8'h24);
    replyByte = 8'hA5;
    replyEn = 1'b1;
    repeat (3) tick();
    rd_status();
    check(portDataLinesOe, 8'h00, "line drive");
    check(portRdData, 8'hA5, "line read");
    replyEn = 1'b0;
    wr_ctrl(8'h04);
    tick();
  endtask
  task automatic test_stretch();
    eppEnable = 1'b1;
    hostCycleActive = 1'b1;
    repeat (2) tick();
    check(hostReadyOe, 8'h01, "stretch");
    check(hostReadyOut, 8'h00, "ready level");
    check(sharedIrqOut, 8'h00, "irq level");
    eppEnable = 1'b0;
    repeat (2) tick();
    check(hostReadyOe, 8'h00, "no stretch");
    hostCycleActive = 1'b0;
  endtask
  task automatic test_stream();
    int n;
    int w;
    n = 0;
    hostDataValid = 1'b1;
    for (int k = 0; k < 20; k++) begin
      hostData = 8'(8'h30 + n);
      if (hostDataReady === 1'b1) n++;
      tick();
    end
    hostDataValid = 1'b0;
    check(8'(n), 8'h09, "fill count");
    slow = 1'b1;
    for (int i = 0; i < 9; i++) begin
      eppEnable = i[0];
      ecpEnable = !i[0];
      check(portDataLinesOut, 8'(8'h30 + i), "byte order");
      wr_ctrl(8'h05);
      wr_ctrl(8'h04);
      repeat (2) tick();
      rd_status();
      check(statusRdData[7], 8'h00, "busy");
      check(lastByte, 8'(8'h30 + i), "byte taken");
      w = 0;
      while (sharedIrqOe !== 1'b1) begin
        tick();
        w++;
        if (w == 60) begin
          errors++;
          report_and_stop();
        end
      end
      w = 0;
      while (sharedIrqOe === 1'b1 && w < 20) begin
        tick();
        w++;
      end
      check(8'(w), 8'h05, "irq width");
      repeat (4) tick();
    end
    {eppEnable, ecpEnable, slow} = 3'h0;
    repeat (2) tick();
    check(sharedIrqOe, 8'h01, "standard irq");
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    {srst, ctrlWrEn, statusRdEn, eppEnable, ecpEnable} = 5'h10;
    {hostDataValid, hostCycleActive, slow, replyEn} = 4'h0;
    {paperOutIn, peripheralOnlineIn, peripheralFaultInN} = 3'h3;
    {ctrlWrData, hostData, replyByte} = 24'h0000_00;
    repeat (2) @(posedge clk_sys);
    #1 srst = 1'b0;
    repeat (3) tick();
    test_ctrl();
    test_status();
    test_dir_in();
    test_stretch();
    test_stream();
    report_and_stop();
  end
endmodule
